/* File: hdl/ssr_pkg.sv */
// Constants and types for the servo setpoint select and ramp block
package ssr_pkg;

////////////////////////////////////////////////////////////////////////////
// Clock and time base
localparam int SSR_CLK_PERIOD_NS = 20;
localparam longint SSR_NS_PER_SEC = 64'd1_000_000_000;
localparam longint SSR_CLK_HZ = SSR_NS_PER_SEC / SSR_CLK_PERIOD_NS;

////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses, one word each)
localparam logic [7:0] SSR_OFS_FIXED_BASE = 8'h00;
localparam logic [7:0] SSR_OFS_MODE = 8'h20;
localparam logic [7:0] SSR_OFS_RAMP_TYPE = 8'h24;
localparam logic [7:0] SSR_OFS_ANALOG_FS = 8'h28;
localparam logic [7:0] SSR_OFS_CLAMP_THR = 8'h2c;
localparam logic [7:0] SSR_OFS_MAX_SPEED = 8'h30;
localparam logic [7:0] SSR_OFS_UP_TIME = 8'h34;
localparam logic [7:0] SSR_OFS_DOWN_TIME = 8'h38;
localparam logic [7:0] SSR_OFS_ROUND_IN = 8'h3c;
localparam logic [7:0] SSR_OFS_ROUND_OUT = 8'h40;
localparam logic [7:0] SSR_OFS_FIX_TORQUE = 8'h44;
localparam logic [7:0] SSR_OFS_TQ_SCALE = 8'h48;
localparam logic [7:0] SSR_OFS_TQ_OFFSET = 8'h4c;
localparam logic [7:0] SSR_OFS_AI_MON = 8'h50;
localparam logic [7:0] SSR_OFS_STATUS = 8'h54;
localparam logic [7:0] SSR_OFS_SPEED_CMD = 8'h58;
localparam logic [7:0] SSR_OFS_TARGET = 8'h5c;

////////////////////////////////////////////////////////////////////////////
// Reset values and ranges
localparam logic signed [31:0] SSR_RST_FIXED = 32'sh0;
localparam logic [7:0] SSR_RST_MODE = 8'h00;
localparam logic SSR_RST_RAMP_TYPE = 1'b0;
localparam logic signed [31:0] SSR_RST_ANALOG_FS = 32'sd3000;
localparam logic signed [31:0] SSR_RST_CLAMP_THR = 32'sd200;
localparam logic signed [31:0] SSR_RST_MAX_SPEED = 32'sd1500;
localparam logic signed [31:0] SSR_RST_RAMP_TIME = 32'sd1;
localparam logic signed [31:0] SSR_RST_ROUND = 32'sd0;
localparam logic signed [31:0] SSR_RST_FIX_TORQUE = 32'sd0;
localparam logic signed [31:0] SSR_RST_TQ_SCALE = 32'sd100;
localparam logic signed [31:0] SSR_RST_TQ_OFFSET = 32'sd0;
localparam logic signed [31:0] SSR_SPEED_LIMIT = 32'sd210000;
localparam logic signed [31:0] SSR_FS_MIN = 32'sd6;
localparam logic signed [31:0] SSR_CLAMP_MAX = 32'sd200;
localparam logic signed [31:0] SSR_TIME_MAX = 32'sd999999;
localparam logic signed [31:0] SSR_ROUND_MAX = 32'sd30;
localparam logic signed [31:0] SSR_TORQUE_PCT_MAX = 32'sd100;
localparam logic signed [31:0] SSR_OFFSET_MV_MAX = 32'sd500;
localparam logic signed [63:0] SSR_ANALOG_FULL_MV = 64'sd10000;
localparam logic signed [31:0] SSR_TORQUE_FRAC = 32'sd100;
localparam logic [7:0] SSR_PULSE_MODE_CODE = 8'h04;

////////////////////////////////////////////////////////////////////////////
// Status field positions
localparam int SSR_ST_LOCK = 0;
localparam int SSR_ST_PULSE = 1;
localparam int SSR_ST_MOVING = 2;
localparam int SSR_ST_DIN = 3;

////////////////////////////////////////////////////////////////////////////
// Types
typedef struct packed {
	logic pulse_train_input;
	logic torque_source_select;
	logic control_mode_change_input;
	logic zero_speed_clamp_request;
	logic counterclockwise_run_enable;
	logic clockwise_run_enable;
	logic speed_select_bit2;
	logic speed_select_bit1;
	logic speed_select_bit0;
} ssr_din_type;

typedef struct packed {
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
} ssr_bus_type;

typedef enum {ph_idle, ph_round_in, ph_full, ph_round_out} ssr_phase_type;

endpackage : ssr_pkg

/* File: hdl/ssr_fixed_table.sv */
// Fixed speed setpoint table with two registered read ports
`timescale 1ns/1ps
module ssr_fixed_table
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Write port
	input wire logic wr_en,
	input wire logic [2:0] wr_index,
	input wire logic signed [31:0] wr_data,
	// Read ports
	input wire logic [2:0] rd_a_index,
	output logic signed [31:0] rd_a_data,
	input wire logic [2:0] rd_b_index,
	output logic signed [31:0] rd_b_data
);

logic signed [31:0] entry [0:7];

// Entry 0 stays zero: code 000 selects the analog path
assign entry[0] = SSR_RST_FIXED;

genvar i;
generate
	for (i = 1; i < 8; i++) begin : g_entry
		logic signed [31:0] value;
		always_ff @(posedge sys_clk) begin
			if (!resetn)
				value <= SSR_RST_FIXED;
			else if (wr_en && wr_index == 3'(i))
				value <= wr_data;
		end
		assign entry[i] = value;
	end
endgenerate

always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		rd_a_data <= SSR_RST_FIXED;
		rd_b_data <= SSR_RST_FIXED;
	end else begin
		rd_a_data <= entry[rd_a_index];
		rd_b_data <= entry[rd_b_index];
	end
end

endmodule : ssr_fixed_table

/* File: hdl/ssr_setpoint_ramp.sv */
// Speed and torque setpoint selection, direction, clamp and ramp
// Summary of operation
// - All selects low picks analog speed input
// - Nonzero select code picks fixed setpoint 1-7
// - Fixed setpoints signed, limited, reset zero
// - Analog 10 V maps to full-scale speed
// - Both enables equal stops the motor
// - Single enable sets direction, analog sign mirrors
// - Clamp only with analog speed source
// - Lock axis when request and both speeds low
// - Leave clamp on request low or setpoint high
// - Clamp threshold 0-200 rpm, default 200
// - Mode 4 with mode input: clamp selects pulses
// - Separate ramp-up and ramp-down times
// - Ramp times referenced to maximum speed
// - Ramp type 1 gives S-curve, 0 linear
// - Rounding times 0-30 s, default zero
// - Torque select picks analog or fixed torque
// - Analog 10 V maps to torque scaling
// - Offset added to analog input 2
// - Analog input 2 readable as monitor
`timescale 1ns/1ps
module ssr_setpoint_ramp
	import ssr_pkg::*;
#(
	parameter longint CYCLES_PER_SEC = SSR_CLK_HZ
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register bus
	input wire ssr_bus_type bus,
	output logic [31:0] rdata,
	// Digital input pins
	input wire ssr_din_type din,
	// Analog samples in mV and speed feedback in rpm
	input wire logic signed [15:0] analog_in1_mv,
	input wire logic signed [15:0] analog_in2_mv,
	input wire logic signed [31:0] actual_speed,
	// Drive commands
	output logic signed [31:0] speed_command,
	output logic signed [31:0] torque_command,
	output logic axis_lock,
	output logic pulse_train_mode,
	output logic position_pulse
);

function automatic logic signed [31:0] sat_range(
	input logic signed [31:0] v,
	input logic signed [31:0] lo,
	input logic signed [31:0] hi);
	sat_range = (v < lo) ? lo : ((v > hi) ? hi : v);
endfunction : sat_range

function automatic logic signed [31:0] mag(input logic signed [31:0] v);
	mag = (v < 0) ? -v : v;
endfunction : mag

////////////////////////////////////////////////////////////////////////////
// Input synchronisers
logic [8:0] sync1;
logic [8:0] sync2;
ssr_din_type din_s;
ssr_din_type din_d;

genvar i;
generate
	for (i = 0; i < 9; i++) begin : g_sync
		always_ff @(posedge sys_clk) begin
			if (!resetn) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
			end else begin
				sync1[i] <= din[i];
				sync2[i] <= sync1[i];
			end
		end
	end
endgenerate
assign din_s = sync2;

////////////////////////////////////////////////////////////////////////////
// Configuration registers
logic [7:0] mode_param;
logic ramp_type_select;
logic signed [31:0] analog_speed_full_scale;
logic signed [31:0] clamp_speed_threshold;
logic signed [31:0] ramp_reference_max_speed;
logic signed [31:0] ramp_up_time;
logic signed [31:0] ramp_down_time;
logic signed [31:0] initial_rounding_time;
logic signed [31:0] final_rounding_time;
logic signed [31:0] fixed_torque_value;
logic signed [31:0] analog_torque_scaling;
logic signed [31:0] torque_input_offset;

wire logic signed [31:0] wval = bus.wdata;
wire logic wr_go = bus.wr;
wire logic tab_hit = bus.addr[7:5] == SSR_OFS_FIXED_BASE[7:5]
	&& bus.addr[1:0] == 2'h0 && bus.addr[4:2] != 3'h0;
wire logic signed [31:0] fixed_wval =
	sat_range(wval, -SSR_SPEED_LIMIT, SSR_SPEED_LIMIT);

always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		mode_param <= SSR_RST_MODE;
		ramp_type_select <= SSR_RST_RAMP_TYPE;
		analog_speed_full_scale <= SSR_RST_ANALOG_FS;
		clamp_speed_threshold <= SSR_RST_CLAMP_THR;
		ramp_reference_max_speed <= SSR_RST_MAX_SPEED;
		ramp_up_time <= SSR_RST_RAMP_TIME;
		ramp_down_time <= SSR_RST_RAMP_TIME;
		initial_rounding_time <= SSR_RST_ROUND;
		final_rounding_time <= SSR_RST_ROUND;
		fixed_torque_value <= SSR_RST_FIX_TORQUE;
		analog_torque_scaling <= SSR_RST_TQ_SCALE;
		torque_input_offset <= SSR_RST_TQ_OFFSET;
	end else if (wr_go) begin
		case (bus.addr)
			SSR_OFS_MODE: mode_param <= bus.wdata[7:0];
			SSR_OFS_RAMP_TYPE: ramp_type_select <= bus.wdata[0];
			SSR_OFS_ANALOG_FS: analog_speed_full_scale <=
				sat_range(wval, SSR_FS_MIN, SSR_SPEED_LIMIT);
			SSR_OFS_CLAMP_THR: clamp_speed_threshold <=
				sat_range(wval, 32'sd0, SSR_CLAMP_MAX);
			SSR_OFS_MAX_SPEED: ramp_reference_max_speed <=
				sat_range(wval, 32'sd0, SSR_SPEED_LIMIT);
			SSR_OFS_UP_TIME: ramp_up_time <=
				sat_range(wval, 32'sd0, SSR_TIME_MAX);
			SSR_OFS_DOWN_TIME: ramp_down_time <=
				sat_range(wval, 32'sd0, SSR_TIME_MAX);
			SSR_OFS_ROUND_IN: initial_rounding_time <=
				sat_range(wval, 32'sd0, SSR_ROUND_MAX);
			SSR_OFS_ROUND_OUT: final_rounding_time <=
				sat_range(wval, 32'sd0, SSR_ROUND_MAX);
			SSR_OFS_FIX_TORQUE: fixed_torque_value <=
				sat_range(wval, -SSR_TORQUE_PCT_MAX, SSR_TORQUE_PCT_MAX);
			SSR_OFS_TQ_SCALE: analog_torque_scaling <=
				sat_range(wval, 32'sd0, SSR_TORQUE_PCT_MAX);
			SSR_OFS_TQ_OFFSET: torque_input_offset <=
				sat_range(wval, -SSR_OFFSET_MV_MAX, SSR_OFFSET_MV_MAX);
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// Fixed setpoint table
logic signed [31:0] tab_bus_data;
logic signed [31:0] fixed_q;
wire logic [2:0] sel_s = {din_s.speed_select_bit2,
	din_s.speed_select_bit1, din_s.speed_select_bit0};

ssr_fixed_table u_table (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.wr_en(wr_go && tab_hit),
	.wr_index(bus.addr[4:2]),
	.wr_data(fixed_wval),
	.rd_a_index(bus.addr[4:2]),
	.rd_a_data(tab_bus_data),
	.rd_b_index(sel_s),
	.rd_b_data(fixed_q)
);

////////////////////////////////////////////////////////////////////////////
// Speed source and direction
logic signed [31:0] target;
logic target_analog;
logic target_req;
wire logic [2:0] sel_d = {din_d.speed_select_bit2,
	din_d.speed_select_bit1, din_d.speed_select_bit0};
// analog source when all selects low
wire logic analog_src = sel_d == 3'h0;
wire logic signed [63:0] speed_prod =
	64'(analog_in1_mv) * 64'(analog_speed_full_scale);
wire logic signed [31:0] analog_speed =
	32'(speed_prod / SSR_ANALOG_FULL_MV);
// fixed table entry by select code
wire logic signed [31:0] source_val =
	analog_src ? analog_speed : mag(fixed_q);
wire logic cw_only = din_d.clockwise_run_enable
	&& !din_d.counterclockwise_run_enable;
wire logic ccw_only = din_d.counterclockwise_run_enable
	&& !din_d.clockwise_run_enable;
// equal enables give zero; mirror with ccw
wire logic signed [31:0] next_target =
	cw_only ? source_val : (ccw_only ? -source_val : 32'sd0);

always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		din_d <= '0;
		target <= 32'sd0;
		target_analog <= 1'b0;
		target_req <= 1'b0;
	end else begin
		din_d <= din_s;
		target <= next_target;
		target_analog <= analog_src;
		target_req <= din_d.zero_speed_clamp_request;
	end
end

////////////////////////////////////////////////////////////////////////////
// Zero speed clamp and pulse train switch
wire logic signed [31:0] tgt_mag = mag(target);
wire logic signed [31:0] act_mag = mag(actual_speed);
wire logic both_low = tgt_mag < clamp_speed_threshold
	&& act_mag < clamp_speed_threshold;
wire logic tgt_high = tgt_mag > clamp_speed_threshold;
logic next_lock;
assign next_lock = (!target_req || !target_analog) ? 1'b0 :
	(axis_lock ? !tgt_high : both_low);
// mode code with mode input and request
wire logic next_pulse_mode = mode_param == SSR_PULSE_MODE_CODE
	&& din_d.control_mode_change_input
	&& din_d.zero_speed_clamp_request;

always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		axis_lock <= 1'b0;
		pulse_train_mode <= 1'b0;
		position_pulse <= 1'b0;
	end else begin
		axis_lock <= next_lock;
		pulse_train_mode <= next_pulse_mode;
		position_pulse <= din_d.pulse_train_input;
	end
end

////////////////////////////////////////////////////////////////////////////
// Ramp generator
ssr_phase_type phase;
ssr_phase_type next_phase;
logic signed [31:0] rate;
logic signed [63:0] acc;
logic signed [63:0] jerk;
wire logic signed [31:0] goal = next_lock ? 32'sd0 : target;
wire logic signed [31:0] diff = goal - speed_command;
wire logic moving = diff != 32'sd0;
wire logic going_up = diff > 32'sd0;
// up time when moving away from zero
wire logic accel = going_up ? speed_command >= 32'sd0 :
	speed_command <= 32'sd0;
wire logic signed [31:0] t_sel = accel ? ramp_up_time : ramp_down_time;
wire logic signed [63:0] lim = 64'(t_sel) * CYCLES_PER_SEC;
wire logic signed [63:0] lim_in =
	64'(initial_rounding_time) * CYCLES_PER_SEC;
wire logic signed [63:0] lim_out =
	64'(final_rounding_time) * CYCLES_PER_SEC;
wire logic signed [31:0] vmax = ramp_reference_max_speed;
// Braking distance of the rounding, kept in products to avoid a divider
wire logic need_out = 64'(rate) * 64'(rate) * 64'(final_rounding_time)
	>= 64'sd2 * 64'(vmax) * 64'(t_sel) * 64'(mag(diff));
// linear uses full rate, S-curve the rounded rate
wire logic signed [31:0] rate_eff = ramp_type_select ? rate : vmax;
wire logic signed [63:0] acc_sum = acc + 64'(rate_eff);
wire logic step = acc_sum >= lim;
wire logic signed [63:0] jerk_sum = jerk + 64'(vmax);
wire logic jerk_in = jerk_sum >= lim_in;
wire logic jerk_out = jerk_sum >= lim_out;

always_comb begin
	next_phase = phase;
	case (phase)
		ph_idle: if (moving) next_phase = ph_round_in;
		ph_round_in: begin
			if (!moving)
				next_phase = ph_idle;
			else if (need_out)
				next_phase = ph_round_out;
			else if (rate >= vmax)
				next_phase = ph_full;
		end
		ph_full: begin
			if (!moving)
				next_phase = ph_idle;
			else if (need_out)
				next_phase = ph_round_out;
		end
		ph_round_out: if (!moving) next_phase = ph_idle;
		default: next_phase = ph_idle;
	endcase
end

// rounding shapes the rate, zero time jumps it
always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		phase <= ph_idle;
		rate <= 32'sd0;
		jerk <= 64'sd0;
	end else begin
		phase <= next_phase;
		if (next_phase != phase || phase == ph_idle)
			jerk <= 64'sd0;
		else if ((phase == ph_round_in && jerk_in)
			|| (phase == ph_round_out && jerk_out))
			jerk <= jerk_sum - (phase == ph_round_in ? lim_in : lim_out);
		else if (phase != ph_full)
			jerk <= jerk_sum;
		if (phase == ph_idle)
			rate <= 32'sd0;
		else if (phase == ph_round_in)
			rate <= (lim_in == 64'sd0 || rate >= vmax) ? vmax :
				rate + 32'(jerk_in);
		else if (phase == ph_round_out)
			rate <= (lim_out == 64'sd0 || rate <= 32'sd1) ? 32'sd1 :
				rate - 32'(jerk_out);
	end
end

// one rpm per overflow of the slope accumulator
always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		speed_command <= 32'sd0;
		acc <= 64'sd0;
	end else if (next_lock || t_sel == 32'sd0) begin
		speed_command <= goal;
		acc <= 64'sd0;
	end else if (!moving) begin
		acc <= 64'sd0;
	end else if (step) begin
		speed_command <= speed_command + (going_up ? 32'sd1 : -32'sd1);
		acc <= acc_sum - lim;
	end else begin
		acc <= acc_sum;
	end
end

////////////////////////////////////////////////////////////////////////////
// Torque setpoint
wire logic signed [31:0] ai2_corr =
	32'(analog_in2_mv) + torque_input_offset;
wire logic signed [63:0] torque_prod =
	64'(ai2_corr) * 64'(analog_torque_scaling);
// 10 V gives scaling in hundredths of a percent
wire logic signed [31:0] analog_torque =
	32'(torque_prod / SSR_ANALOG_FULL_MV * 64'(SSR_TORQUE_FRAC));
wire logic signed [31:0] fixed_torque = fixed_torque_value * SSR_TORQUE_FRAC;

always_ff @(posedge sys_clk) begin
	if (!resetn)
		torque_command <= 32'sd0;
	else
		torque_command <= din_d.torque_source_select ?
			fixed_torque : analog_torque;
end

////////////////////////////////////////////////////////////////////////////
// Register read path
logic [31:0] reg_q;
logic rd_q;
logic tab_q;
logic [31:0] status;
assign status = {20'h0, din_s, ~moving ? 1'b0 : 1'b1,
	pulse_train_mode, axis_lock};
wire logic [31:0] read_mux =
	(bus.addr == SSR_OFS_MODE) ? {24'h0, mode_param} :
	(bus.addr == SSR_OFS_RAMP_TYPE) ? {31'h0, ramp_type_select} :
	(bus.addr == SSR_OFS_ANALOG_FS) ? analog_speed_full_scale :
	(bus.addr == SSR_OFS_CLAMP_THR) ? clamp_speed_threshold :
	(bus.addr == SSR_OFS_MAX_SPEED) ? ramp_reference_max_speed :
	(bus.addr == SSR_OFS_UP_TIME) ? ramp_up_time :
	(bus.addr == SSR_OFS_DOWN_TIME) ? ramp_down_time :
	(bus.addr == SSR_OFS_ROUND_IN) ? initial_rounding_time :
	(bus.addr == SSR_OFS_ROUND_OUT) ? final_rounding_time :
	(bus.addr == SSR_OFS_FIX_TORQUE) ? fixed_torque_value :
	(bus.addr == SSR_OFS_TQ_SCALE) ? analog_torque_scaling :
	(bus.addr == SSR_OFS_TQ_OFFSET) ? torque_input_offset :
	(bus.addr == SSR_OFS_AI_MON) ? 32'(analog_in2_mv) :
	(bus.addr == SSR_OFS_STATUS) ? status :
	(bus.addr == SSR_OFS_SPEED_CMD) ? speed_command :
	(bus.addr == SSR_OFS_TARGET) ? target : 32'h0;

always_ff @(posedge sys_clk) begin
	if (!resetn) begin
		reg_q <= 32'h0;
		rd_q <= 1'b0;
		tab_q <= 1'b0;
	end else begin
		reg_q <= bus.rd ? read_mux : 32'h0;
		rd_q <= bus.rd;
		tab_q <= bus.rd && tab_hit;
	end
end
// Table word comes from its own read register, hence the late mux
assign rdata = !rd_q ? 32'h0 : (tab_q ? tab_bus_data : reg_q);

////////////////////////////////////////////////////////////////////////////
// Checks
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!resetn);

a_analog_source: assert property (analog_src && cw_only
	|=> target == $past(analog_speed)) else $error("analog path wrong");
a_fixed_source: assert property (!analog_src && cw_only
	|=> target == mag($past(fixed_q))) else $error("fixed path wrong");
a_stop_equal: assert property (din_d.clockwise_run_enable
	== din_d.counterclockwise_run_enable |=> target == 32'sd0)
	else $error("motor not stopped");
a_mirror_dir: assert property (ccw_only
	|=> target == -$past(source_val)) else $error("ccw not mirrored");
a_clamp_analog: assert property (!target_analog
	|=> !axis_lock) else $error("clamp on fixed source");
a_clamp_enter: assert property (target_req && target_analog
	&& both_low |=> axis_lock ##0 speed_command == 32'sd0)
	else $error("clamp not entered");
a_clamp_leave: assert property (axis_lock && (!target_req
	|| tgt_high) |=> !axis_lock) else $error("clamp not left");
a_thr_range: assert property (clamp_speed_threshold <= SSR_CLAMP_MAX
	&& clamp_speed_threshold >= 32'sd0) else $error("threshold range");
a_pulse_mode: assert property (next_pulse_mode
	|=> pulse_train_mode [*1] ##1 $past(din_d.pulse_train_input)
	== position_pulse) else $error("pulse mode wrong");
a_ramp_slope: assert property (!next_lock && t_sel != 32'sd0
	|=> mag(speed_command - $past(speed_command)) <= 32'sd1)
	else $error("ramp too steep");
a_ramp_jump: assert property (!next_lock && t_sel == 32'sd0
	|=> speed_command == $past(goal)) else $error("zero time no jump");
a_torque_src: assert property (din_d.torque_source_select
	|=> torque_command == $past(fixed_torque)) else $error("torque src");

c_clamp: cover property (!axis_lock ##1 axis_lock);
c_pulse: cover property (pulse_train_mode);
c_arrive: cover property (moving ##1 !moving && target != 32'sd0);
c_scurve: cover property (ramp_type_select && phase == ph_round_out);

endmodule : ssr_setpoint_ramp

/* File: tb/ssr_host_model.sv */
// Host controller model driving digital pins, analog inputs and feedback
`timescale 1ns/1ps
module ssr_host_model
	import ssr_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Toward the drive
	output ssr_din_type din,
	output logic signed [15:0] analog_in1_mv,
	output logic signed [15:0] analog_in2_mv,
	output logic signed [31:0] actual_speed
);
	// Motor held still, so feedback stays at zero
	initial begin
		din = '0;
		analog_in1_mv = 16'sh0;
		analog_in2_mv = 16'sh0;
		actual_speed = 32'sh0;
	end

	////////////////////////////////////////////////////////////////////////
	// Pins move just after an edge, as a host output stage would
	task automatic drive(input ssr_din_type d, input logic signed [15:0] a1,
		input logic signed [15:0] a2);
		@(posedge sys_clk);
		din <= d;
		analog_in1_mv <= a1;
		analog_in2_mv <= a2;
	endtask : drive
endmodule : ssr_host_model

/* File: tb/tb_top.sv */
// Self-checking bench for the setpoint select and ramp block
`timescale 1ns/1ps
module tb_top
	import ssr_pkg::*;
;
	// Short second, yet slopes stay below one rpm per cycle
	localparam longint CPS = 3000;
	localparam logic [4:0] CW = 5'b00001;
	localparam logic [4:0] CCW = 5'b00010;
	localparam logic [4:0] BOTH = 5'b00011;
	localparam logic [4:0] REQ = 5'b00100;
	localparam logic [4:0] CM = 5'b01000;
	localparam logic [4:0] TS = 5'b10000;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	ssr_bus_type bus = '0;
	ssr_din_type din;
	logic [31:0] rdata;
	logic [31:0] r;
	logic signed [15:0] ai1;
	logic signed [15:0] ai2;
	logic signed [31:0] act;
	logic signed [31:0] spd;
	logic signed [31:0] trq;
	logic lock;
	logic pmode;
	logic ppulse;
	int num_errors = 0;
	int num_checks = 0;
	int n;
	int c;

	always #10 sys_clk = ~sys_clk;

	ssr_host_model host (.sys_clk(sys_clk), .din(din), .analog_in1_mv(ai1),
		.analog_in2_mv(ai2), .actual_speed(act));
	ssr_setpoint_ramp #(.CYCLES_PER_SEC(CPS)) dut (.sys_clk(sys_clk),
		.resetn(resetn), .bus(bus), .rdata(rdata), .din(din),
		.analog_in1_mv(ai1), .analog_in2_mv(ai2), .actual_speed(act),
		.speed_command(spd), .torque_command(trq), .axis_lock(lock),
		.pulse_train_mode(pmode), .position_pulse(ppulse));

	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %0d seen %0d", what, $signed(exp),
				$signed(seen));
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask : wr

	// Read data stands one cycle only, so sample just after its edge
	task automatic rchk(input string what, input logic [7:0] a,
		input logic [31:0] e);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1;
		check(what, rdata, e);
	endtask : rchk

	// Pin change reaches the commands within five edges
	task automatic pins(input logic [2:0] s, input logic [4:0] f,
		input logic signed [15:0] a1, input logic signed [15:0] a2);
		host.drive({1'b0, f, s}, a1, a2);
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : pins

	task automatic ramp_to(input logic [2:0] s, input logic [4:0] f,
		input logic [31:0] goal);
		host.drive({1'b0, f, s}, 16'sh0, 16'sh0);
		c = 0;
		while (spd !== goal && c < 5000) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask : ramp_to

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		close_out();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		rchk("fixed7", 8'h1c, 32'h0);
		rchk("full_scale", SSR_OFS_ANALOG_FS, 32'd3000);
		rchk("threshold", SSR_OFS_CLAMP_THR, 32'd200);
		rchk("max_speed", SSR_OFS_MAX_SPEED, 32'd1500);
		rchk("up_time", SSR_OFS_UP_TIME, 32'h1);
		rchk("round_in", SSR_OFS_ROUND_IN, 32'h0);
		rchk("tq_scale", SSR_OFS_TQ_SCALE, 32'd100);
		wr(8'h04, 32'd300000);
		rchk("fixed1_sat", 8'h04, 32'd210000);
		wr(SSR_OFS_CLAMP_THR, 32'd500);
		rchk("thr_sat", SSR_OFS_CLAMP_THR, 32'd200);
		wr(SSR_OFS_UP_TIME, 32'h0);
		wr(SSR_OFS_DOWN_TIME, 32'h0);
		for (n = 1; n < 8; n++)
			wr(8'(4 * n), 32'(100 * n));
		for (n = 1; n < 8; n++) begin
			pins(3'(n), CW, 16'sh0, 16'sh0);
			check("fixed_cw", spd, 32'(100 * n));
			pins(3'(n), CCW, 16'sh0, 16'sh0);
			check("fixed_ccw", spd, 32'(-100 * n));
			pins(3'(n), BOTH, 16'sh0, 16'sh0);
			check("both_on", spd, 32'h0);
		end
		pins(3'h0, CW, 16'sd5000, 16'sh0);
		check("analog_pos", spd, 32'd1500);
		pins(3'h0, CW, -16'sd2000, 16'sh0);
		check("analog_neg", spd, -32'sd600);
		pins(3'h0, CCW, -16'sd2000, 16'sh0);
		check("analog_ccw", spd, 32'd600);
		pins(3'h0, 5'h0, 16'sd5000, 16'sh0);
		check("none_on", spd, 32'h0);
		pins(3'h0, CW | REQ, 16'sh0, 16'sh0);
		check("clamp_on", 32'(lock), 32'h1);
		pins(3'h0, CW | REQ, 16'sd1000, 16'sh0);
		check("clamp_fast", 32'(lock), 32'h0);
		pins(3'h0, CW | REQ, 16'sh0, 16'sh0);
		pins(3'h0, CW, 16'sh0, 16'sh0);
		check("clamp_off", 32'(lock), 32'h0);
		pins(3'h1, CW | REQ, 16'sh0, 16'sh0);
		check("clamp_fixed", 32'(lock), 32'h0);
		wr(SSR_OFS_MODE, 32'h4);
		pins(3'h0, CW | REQ | CM, 16'sh0, 16'sh0);
		check("pulse_on", 32'(pmode), 32'h1);
		host.drive({1'b1, CW | REQ | CM, 3'h0}, 16'sh0, 16'sh0);
		repeat (8) @(posedge sys_clk);
		#1;
		check("pulse_pass", 32'(ppulse), 32'h1);
		pins(3'h0, CW | CM, 16'sh0, 16'sh0);
		check("pulse_off", 32'(pmode), 32'h0);
		wr(SSR_OFS_FIX_TORQUE, 32'd50);
		pins(3'h0, TS, 16'sh0, 16'sh0);
		check("tq_fixed", trq, 32'd5000);
		wr(SSR_OFS_TQ_SCALE, 32'd50);
		pins(3'h0, 5'h0, 16'sh0, 16'sd6000);
		check("tq_analog", trq, 32'd3000);
		wr(SSR_OFS_TQ_OFFSET, 32'd500);
		pins(3'h0, 5'h0, 16'sh0, 16'sd5500);
		check("tq_offset", trq, 32'd3000);
		rchk("ai_monitor", SSR_OFS_AI_MON, 32'd5500);
		// Ramps: 1500 rpm per second is half an rpm each cycle here
		wr(8'h04, 32'd300);
		pins(3'h1, BOTH, 16'sh0, 16'sh0);
		wr(SSR_OFS_UP_TIME, 32'h1);
		wr(SSR_OFS_DOWN_TIME, 32'h2);
		ramp_to(3'h1, CW, 32'd300);
		check("ramp_up", 32'(c >= 595 && c <= 615), 32'h1);
		ramp_to(3'h1, BOTH, 32'h0);
		check("ramp_down", 32'(c >= 1195 && c <= 1215), 32'h1);
		wr(SSR_OFS_RAMP_TYPE, 32'h1);
		wr(SSR_OFS_ROUND_IN, 32'h1);
		wr(SSR_OFS_ROUND_OUT, 32'h1);
		ramp_to(3'h1, CW, 32'd300);
		check("s_curve", 32'(c > 615 && c < 5000), 32'h1);
		close_out();
	end
endmodule : tb_top
